/* File: mpf_top.v */
// mac phy management and flow control registers behind an ahb-lite slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "mpf_defines.vh"
module mpf_top (
  input  wire        i_clk_sys,
  input  wire        i_rst_b,
  // ahb-lite slave
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  // management link
  input  wire        i_mdio_in,
  output reg         o_mdc,
  output reg         o_mdio_out,
  output reg         o_mdio_oe,
  // flow control requests from the mac fifo logic
  input  wire        i_pause_req,
  input  wire        i_bp_req,
  // transmit side for pause frames
  input  wire        i_tx_ready,
  output wire        o_tx_valid,
  output wire [7:0]  o_tx_data,
  output wire        o_tx_last,
  output reg         o_backpressure,
  output reg         o_tx_pause,
  // receive side status
  input  wire        i_rx_done,
  input  wire        i_rx_is_pause,
  input  wire        i_rx_ok,
  input  wire [15:0] i_rx_quanta,
  input  wire        i_rx_filter_pass,
  input  wire        i_promisc,
  output reg         o_rx_stat_valid,
  output reg         o_rx_filter_ok,
  output reg         o_rx_is_ctrl
);
  reg         acc_busy_r;
  reg         acc_wr_r;
  reg  [4:0]  acc_phy_r;
  reg  [4:0]  acc_reg_r;
  reg  [15:0] data_r;
  reg  [15:0] ptime_r;
  reg         fpass_r;
  reg         fen_r;
  reg         tx_en_r;
  reg         fdx_r;
  reg         aph_wr_r;
  reg  [7:0]  aph_addr_r;
  reg         start_r;
  reg  [31:0] rd_nxt;
  wire        mf_mdc;
  wire        mf_out;
  wire        mf_oe;
  wire        mf_done;
  wire [15:0] mf_rdata;
  wire        fc_busy;
  wire        fc_valid;
  wire [7:0]  fc_data;
  wire        fc_last;
  wire        fc_bp;
  wire        fc_pause;
  wire        rx_pause_act;
  wire        aph = i_hsel && i_hready && i_htrans[1];
  assign rx_pause_act = i_rx_done && i_rx_is_pause && i_rx_ok && fen_r && fdx_r;
  // byte stream leaves the builder's own flops so valid, data and ready share one cycle
  assign o_tx_valid = fc_valid;
  assign o_tx_data  = fc_data;
  assign o_tx_last  = fc_last;

  mpf_mdio_frame u_mdio (
    .i_clk_sys  (i_clk_sys),
    .i_rst_b    (i_rst_b),
    .i_start    (start_r),
    .i_write    (acc_wr_r),
    .i_phy_addr (acc_phy_r),
    .i_reg_idx  (acc_reg_r),
    .i_wdata    (data_r),
    .i_mdio_in  (i_mdio_in),
    .o_mdc      (mf_mdc),
    .o_mdio_out (mf_out),
    .o_mdio_oe  (mf_oe),
    .o_done     (mf_done),
    .o_rdata    (mf_rdata)
  );

  mpf_pause_tx u_pause (
    .i_clk_sys      (i_clk_sys),
    .i_rst_b        (i_rst_b),
    .i_send         (i_pause_req && fen_r),
    .i_bp_req       (i_bp_req && fen_r),
    .i_fdx          (fdx_r),
    .i_tx_en        (tx_en_r),
    .i_pause_time   (ptime_r),
    .i_tx_ready     (i_tx_ready),
    .i_rx_pause     (rx_pause_act),
    .i_rx_quanta    (i_rx_quanta),
    .o_busy         (fc_busy),
    .o_tx_valid     (fc_valid),
    .o_tx_data      (fc_data),
    .o_tx_last      (fc_last),
    .o_backpressure (fc_bp),
    .o_tx_pause     (fc_pause)
  );

  // read mux for the data phase
  always @* begin
    rd_nxt = 32'h00000000;
    case (i_haddr[7:0])
      `MPF_ADDR_ACCESS: begin
        rd_nxt[`MPF_ACC_PHY_HI:`MPF_ACC_PHY_LO] = acc_phy_r;
        rd_nxt[`MPF_ACC_REG_HI:`MPF_ACC_REG_LO] = acc_reg_r;
        rd_nxt[`MPF_ACC_WRITE] = acc_wr_r;
        rd_nxt[`MPF_ACC_BUSY] = acc_busy_r;
      end
      `MPF_ADDR_DATA: rd_nxt[15:0] = data_r;
      `MPF_ADDR_FLOW: begin
        rd_nxt[`MPF_FLOW_PT_HI:`MPF_FLOW_PT_LO] = ptime_r;
        rd_nxt[`MPF_FLOW_PASS] = fpass_r;
        rd_nxt[`MPF_FLOW_EN] = fen_r;
        rd_nxt[`MPF_FLOW_BUSY] = fc_busy;
      end
      `MPF_ADDR_CTRL: begin
        rd_nxt[`MPF_CTRL_TX_EN] = tx_en_r;
        rd_nxt[`MPF_CTRL_FDX] = fdx_r;
      end
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // ahb-lite: zero wait states, always okay
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aph_wr_r <= 1'b0;
      aph_addr_r <= 8'h00;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      aph_wr_r <= aph && i_hwrite;
      aph_addr_r <= i_haddr[7:0];
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (aph && !i_hwrite)
        o_hrdata <= rd_nxt;
    end
  end

  // register writes and management access control
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_busy_r <= 1'b0;
      acc_wr_r <= 1'b0;
      acc_phy_r <= 5'h00;
      acc_reg_r <= 5'h00;
      data_r <= 16'h0000;
      ptime_r <= 16'h0000;
      fpass_r <= 1'b0;
      fen_r <= 1'b0;
      tx_en_r <= 1'b0;
      fdx_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (aph_wr_r) begin
        case (aph_addr_r)
          `MPF_ADDR_ACCESS: begin
            if (!acc_busy_r && i_hwdata[`MPF_ACC_BUSY]) begin
              acc_phy_r  <= i_hwdata[`MPF_ACC_PHY_HI:`MPF_ACC_PHY_LO];
              acc_reg_r  <= i_hwdata[`MPF_ACC_REG_HI:`MPF_ACC_REG_LO];
              acc_wr_r   <= i_hwdata[`MPF_ACC_WRITE];
              acc_busy_r <= 1'b1;
              start_r    <= 1'b1;
            end else if (!acc_busy_r) begin
              acc_phy_r <= i_hwdata[`MPF_ACC_PHY_HI:`MPF_ACC_PHY_LO];
              acc_reg_r <= i_hwdata[`MPF_ACC_REG_HI:`MPF_ACC_REG_LO];
              acc_wr_r  <= i_hwdata[`MPF_ACC_WRITE];
            end
          end
          `MPF_ADDR_DATA: if (!acc_busy_r) data_r <= i_hwdata[15:0];
          `MPF_ADDR_FLOW: if (!fc_busy) begin
            ptime_r <= i_hwdata[`MPF_FLOW_PT_HI:`MPF_FLOW_PT_LO];
            fpass_r <= i_hwdata[`MPF_FLOW_PASS];
            fen_r   <= i_hwdata[`MPF_FLOW_EN];
          end
          `MPF_ADDR_CTRL: begin
            tx_en_r <= i_hwdata[`MPF_CTRL_TX_EN];
            fdx_r   <= i_hwdata[`MPF_CTRL_FDX];
          end
          default: ;
        endcase
      end
      // completion clears busy; read data captured in the same edge
      if (mf_done && acc_busy_r) begin
        acc_busy_r <= 1'b0;
        if (!acc_wr_r)
          data_r <= mf_rdata;
      end
    end
  end

  // receive status: all frames delivered, filter bit reflects pass setting
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_stat_valid <= 1'b0;
      o_rx_filter_ok <= 1'b0;
      o_rx_is_ctrl <= 1'b0;
    end else begin
      o_rx_stat_valid <= i_rx_done;
      o_rx_is_ctrl <= i_rx_done && i_rx_is_pause && fen_r;
      if (i_rx_done) begin
        if (i_promisc)
          o_rx_filter_ok <= 1'b1;
        else if (i_rx_is_pause && fen_r && !fpass_r)
          o_rx_filter_ok <= 1'b0;
        else
          o_rx_filter_ok <= i_rx_filter_pass;
      end
    end
  end

  // registered pin, back pressure and pause outputs
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mdc <= 1'b0;
      o_mdio_out <= 1'b1;
      o_mdio_oe <= 1'b0;
      o_backpressure <= 1'b0;
      o_tx_pause <= 1'b0;
    end else begin
      o_mdc <= mf_mdc;
      o_mdio_out <= mf_out;
      o_mdio_oe <= mf_oe;
      o_backpressure <= fc_bp;
      o_tx_pause <= fc_pause;
    end
  end
endmodule

/* File: mpf_defines.vh */
// register offsets, field positions, reset values and timing counts for the mac mgmt/flow block
`ifndef MPF_DEFINES_VH
`define MPF_DEFINES_VH
`define MPF_IDX_ACCESS      4'h6
`define MPF_IDX_DATA        4'h7
`define MPF_IDX_FLOW        4'h8
`define MPF_IDX_CTRL        4'hC
`define MPF_ADDR_ACCESS     8'h18
`define MPF_ADDR_DATA       8'h1C
`define MPF_ADDR_FLOW       8'h20
`define MPF_ADDR_CTRL       8'h30
`define MPF_ACC_BUSY        0
`define MPF_ACC_WRITE       1
`define MPF_ACC_REG_LO      6
`define MPF_ACC_REG_HI      10
`define MPF_ACC_PHY_LO      11
`define MPF_ACC_PHY_HI      15
`define MPF_FLOW_BUSY       0
`define MPF_FLOW_EN         1
`define MPF_FLOW_PASS       2
`define MPF_FLOW_PT_LO      16
`define MPF_FLOW_PT_HI      31
`define MPF_CTRL_TX_EN      0
`define MPF_CTRL_FDX        1
`define MPF_RST_ACCESS      32'h00000000
`define MPF_RST_DATA        32'h00000000
`define MPF_RST_FLOW        32'h00000000
`define MPF_RST_CTRL        32'h00000000
`define MPF_INT_PHY_ADDR    5'h01
`define MPF_MDC_HALF_NS     200
`define MPF_CLK_NS          8
`define MPF_MDC_HALF_CYC    ((`MPF_MDC_HALF_NS + `MPF_CLK_NS - 1) / `MPF_CLK_NS)
`define MPF_SLOT_BITS       512
`define MPF_PAUSE_OPCODE    16'h0001
`define MPF_CTRL_TYPE       16'h8808
`endif

/* File: mpf_mdio_frame.v */
// clause 22 serial management frame engine
`timescale 1ns/1ps
`include "mpf_defines.vh"
module mpf_mdio_frame #(
  parameter HALF_CYC = `MPF_MDC_HALF_CYC
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_b,
  input  wire        i_start,
  input  wire        i_write,
  input  wire [4:0]  i_phy_addr,
  input  wire [4:0]  i_reg_idx,
  input  wire [15:0] i_wdata,
  input  wire        i_mdio_in,
  output reg         o_mdc,
  output reg         o_mdio_out,
  output reg         o_mdio_oe,
  output reg         o_done,
  output reg  [15:0] o_rdata
);
  reg [7:0]  div_r;
  reg [6:0]  bit_r;
  reg        run_r;
  reg [63:0] sh_r;
  wire       tick = (div_r == HALF_CYC[7:0] - 8'h01);
  // frame: 32 preamble, st, op, phy, reg, ta, 16 data
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_r <= 8'h00; bit_r <= 7'h00; run_r <= 1'b0; sh_r <= 64'h0;
      o_mdc <= 1'b0; o_mdio_out <= 1'b1; o_mdio_oe <= 1'b0;
      o_done <= 1'b0; o_rdata <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      if (!run_r) begin
        div_r <= 8'h00;
        if (i_start) begin
          run_r <= 1'b1;
          bit_r <= 7'h00;
          sh_r  <= {32'hFFFFFFFF, 2'b01, i_write ? 2'b01 : 2'b10,
                    i_phy_addr, i_reg_idx, i_write ? 2'b10 : 2'b11,
                    i_write ? i_wdata : 16'hFFFF};
        end
      end else if (tick) begin
        div_r <= 8'h00;
        o_mdc <= ~o_mdc;
        if (!o_mdc) begin
          // rising edge of mdc: sample read data, phy drives on falling
          if (!i_write && bit_r > 7'd47)
            o_rdata <= {o_rdata[14:0], i_mdio_in};
        end else begin
          // falling edge: present next bit
          if (bit_r == 7'd64) begin
            run_r <= 1'b0; o_done <= 1'b1; o_mdio_oe <= 1'b0;
          end else begin
            o_mdio_out <= sh_r[63];
            o_mdio_oe  <= i_write || bit_r < 7'd46;
            sh_r  <= {sh_r[62:0], 1'b1};
            bit_r <= bit_r + 7'h01;
          end
        end
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end
endmodule

/* File: mpf_pause_tx.v */
// pause frame builder, pause timer and back pressure
`timescale 1ns/1ps
`include "mpf_defines.vh"
module mpf_pause_tx (
  input  wire        i_clk_sys,
  input  wire        i_rst_b,
  input  wire        i_send,
  input  wire        i_bp_req,
  input  wire        i_fdx,
  input  wire        i_tx_en,
  input  wire [15:0] i_pause_time,
  input  wire        i_tx_ready,
  input  wire        i_rx_pause,
  input  wire [15:0] i_rx_quanta,
  output reg         o_busy,
  output reg         o_tx_valid,
  output reg  [7:0]  o_tx_data,
  output reg         o_tx_last,
  output reg         o_backpressure,
  output reg         o_tx_pause
);
  reg [5:0]  idx_r;
  reg        snd_r;
  reg [24:0] ptmr_r;
  reg [7:0]  byte_nxt;
  localparam [15:0] CTL_TYPE = `MPF_CTRL_TYPE;
  localparam [15:0] PAUSE_OP = `MPF_PAUSE_OPCODE;
  // 802.3x control frame bytes from the destination address on, source address bytes left zero
  always @* begin
    case (idx_r)
      6'd0:  byte_nxt = 8'h01; 6'd1: byte_nxt = 8'h80; 6'd2: byte_nxt = 8'hC2;
      6'd3:  byte_nxt = 8'h00; 6'd4: byte_nxt = 8'h00; 6'd5: byte_nxt = 8'h01;
      6'd12: byte_nxt = CTL_TYPE[15:8];
      6'd13: byte_nxt = CTL_TYPE[7:0];
      6'd14: byte_nxt = PAUSE_OP[15:8];
      6'd15: byte_nxt = PAUSE_OP[7:0];
      6'd16: byte_nxt = i_pause_time[15:8];
      6'd17: byte_nxt = i_pause_time[7:0];
      default: byte_nxt = 8'h00;
    endcase
  end
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idx_r <= 6'h00; snd_r <= 1'b0; ptmr_r <= 25'h0; o_busy <= 1'b0;
      o_tx_valid <= 1'b0; o_tx_data <= 8'h00; o_tx_last <= 1'b0;
      o_backpressure <= 1'b0; o_tx_pause <= 1'b0;
    end else begin
      // full duplex: busy from request until last byte taken
      if (!snd_r) begin
        if (i_send && i_fdx && i_tx_en) begin
          snd_r <= 1'b1; idx_r <= 6'h00; o_busy <= 1'b1;
        end
      end else if (!o_tx_valid || i_tx_ready) begin
        if (o_tx_valid && o_tx_last) begin
          snd_r <= 1'b0; o_tx_valid <= 1'b0; o_tx_last <= 1'b0;
          o_busy <= 1'b0;
        end else begin
          o_tx_valid <= 1'b1;
          o_tx_data  <= byte_nxt;
          o_tx_last  <= (idx_r == 6'd59);
          idx_r      <= idx_r + 6'h01;
        end
      end
      // half duplex back pressure held while requested
      o_backpressure <= i_bp_req && !i_fdx && i_tx_en;
      if (!snd_r && !(i_send && i_fdx && i_tx_en))
        o_busy <= i_bp_req && !i_fdx && i_tx_en;
      // received pause: stop transmitter for quanta times slot time
      if (i_rx_pause)
        ptmr_r <= {i_rx_quanta, 9'h000};
      else if (ptmr_r != 25'h0)
        ptmr_r <= ptmr_r - 25'h1;
      o_tx_pause <= i_rx_pause ? (i_rx_quanta != 16'h0) : (ptmr_r > 25'h1);
    end
  end
endmodule

/* File: mpf_top_assertions.sv */
// checker for the mac mgmt and flow block ports
`timescale 1ns/1ps
`include "mpf_defines.vh"
module mpf_top_chk (
  input wire        i_clk_sys,
  input wire        i_rst_b,
  input wire        i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0]  i_htrans,
  input wire        i_hwrite,
  input wire [31:0] i_hwdata,
  input wire        i_hready,
  input wire        i_bp_req,
  input wire        i_tx_ready,
  input wire        i_rx_done,
  input wire        i_rx_is_pause,
  input wire        i_rx_ok,
  input wire        i_promisc,
  input wire        o_mdc,
  input wire        o_tx_valid,
  input wire [7:0]  o_tx_data,
  input wire        o_tx_last,
  input wire        o_backpressure,
  input wire        o_tx_pause,
  input wire        o_rx_stat_valid,
  input wire        o_rx_filter_ok
);
  reg        wv_r;
  reg [7:0]  wa_r;
  reg [31:0] ctl_r;
  reg [31:0] flw_r;
  reg [5:0]  bc_r;
  reg [12:0] st_r;
  // shadow of written registers, cycles since a start, pause bytes taken
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wv_r  <= 1'b0;
      wa_r  <= 8'h00;
      ctl_r <= 32'h00000000;
      flw_r <= 32'h00000000;
      bc_r  <= 6'h00;
      st_r  <= 13'h1FFF;
    end else begin
      wv_r <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
      wa_r <= i_haddr[7:0];
      if (wv_r && wa_r == `MPF_ADDR_CTRL) ctl_r <= i_hwdata;
      if (wv_r && wa_r == `MPF_ADDR_FLOW) flw_r <= i_hwdata;
      if (wv_r && wa_r == `MPF_ADDR_ACCESS && i_hwdata[0]) st_r <= 13'h0000;
      else if (st_r != 13'h1FFF) st_r <= st_r + 13'h0001;
      if (o_tx_valid && i_tx_ready) bc_r <= o_tx_last ? 6'h00 : bc_r + 6'h01;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence pause_in_s;
    i_rx_done && i_rx_is_pause && i_rx_ok && ctl_r[1] && flw_r[1];
  endsequence
  sequence pause_on_s;
    ##[1:3] o_tx_pause;
  endsequence
  mdc_start_a: assert property ($changed(o_mdc) |-> st_r < 13'h0FA0)
    else $error("mgmt clock moved without a start");
  bp_on_a: assert property ((i_bp_req && flw_r[1] && ctl_r[0] && !ctl_r[1]) [*3] |-> o_backpressure)
    else $error("back pressure missing");
  tx_off_a: assert property (!ctl_r[0] [*3] |-> !o_tx_valid && !o_backpressure)
    else $error("activity with transmitter off");
  last_byte_a: assert property (o_tx_valid && o_tx_last |-> bc_r == 6'h3B)
    else $error("pause frame length wrong");
  pt_byte_a: assert property (o_tx_valid && bc_r == 6'h10 |-> o_tx_data == flw_r[31:24])
    else $error("pause time byte wrong");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("pause byte dropped while stalled");
  rx_pause_a: assert property (pause_in_s |-> pause_on_s)
    else $error("received pause not acted on");
  rx_stat_a: assert property (i_rx_done |-> ##[1:2] o_rx_stat_valid)
    else $error("no receive status");
  promisc_a: assert property (i_rx_done && i_promisc |-> ##[1:2] (o_rx_stat_valid && o_rx_filter_ok))
    else $error("promiscuous filter bit wrong");
endmodule
bind mpf_top mpf_top_chk u_chk (.*);

/* File: mpf_phy_model.sv */
// clause 22 phy model answering on a pulled-up data line
`timescale 1ns/1ps
module mpf_phy_model #(
  parameter PHY_ADDR = 5'h01
) (
  input  wire i_mdc,
  input  wire i_mdio,
  output reg  o_drv_en,
  output reg  o_drv_bit
);
  reg [15:0] regs [0:31];
  reg [29:0] fr_r;
  reg [4:0]  ra_r;
  reg        rd_r;
  reg        wr_r;
  integer    k;
  integer    i;
  initial begin
    for (i = 0; i < 32; i = i + 1) regs[i] = 16'h1111 * i;
    {fr_r, rd_r, wr_r, o_drv_en, o_drv_bit} = 34'h0;
    k = 0;
  end
  // shift bits in at mdc rise; k counts bits after the start pattern
  always @(posedge i_mdc) begin
    fr_r <= {fr_r[28:0], i_mdio};
    if (k == 0) k <= (fr_r[3:0] == 4'hE && i_mdio) ? 1 : 0;
    else k <= (k == 30) ? 0 : k + 1;
    if (k == 12) begin
      rd_r <= fr_r[10:9] == 2'b10 && fr_r[8:4] == PHY_ADDR;
      wr_r <= fr_r[10:9] == 2'b01 && fr_r[8:4] == PHY_ADDR;
      ra_r <= {fr_r[3:0], i_mdio};
    end
    if (k == 30 && wr_r) regs[ra_r] <= {fr_r[14:0], i_mdio};
  end
  // drive second turnaround bit and read data after mdc falls
  always @(negedge i_mdc) begin
    o_drv_en <= rd_r && k >= 14;
    o_drv_bit <= (k >= 15) ? regs[ra_r][30 - k] : 1'b0;
  end
endmodule

/* File: mac_phy_mgmt_flow_ctrl_tb.sv */
// self-checking bench for the mac mgmt and flow block
`timescale 1ns/1ps
`include "mpf_defines.vh"
module mac_phy_mgmt_flow_ctrl_tb;
  reg         i_clk_sys, i_rst_b, i_hsel, i_hwrite, i_pause_req, i_bp_req, i_tx_ready;
  reg         i_rx_done, i_rx_is_pause, i_rx_ok, i_rx_filter_pass, i_promisc;
  reg  [31:0] i_haddr, i_hwdata;
  reg  [1:0]  i_htrans;
  reg  [2:0]  i_hsize;
  reg  [15:0] i_rx_quanta;
  wire [31:0] o_hrdata;
  wire [7:0]  o_tx_data;
  wire        o_hreadyout, o_hresp, o_mdc, o_mdio_out, o_mdio_oe, o_tx_valid, o_tx_last;
  wire        o_backpressure, o_tx_pause, o_rx_stat_valid, o_rx_filter_ok, phy_en, phy_bit;
  wire        o_rx_is_ctrl;
  wire        i_hready = o_hreadyout;
  // data line is pulled up when nobody drives it
  wire        i_mdio_in = o_mdio_oe ? o_mdio_out : (phy_en ? phy_bit : 1'b1);
  integer     n_fail = 0, compares = 0, cyc = 0;
  mpf_top i_dut (.*);
  mpf_phy_model i_phy (.i_mdc(o_mdc), .i_mdio(i_mdio_in), .o_drv_en(phy_en), .o_drv_bit(phy_bit));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // cut a hang short
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      $display("timeout");
      wrap_up;
    end
  end
  task wrap_up;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task cmp(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one single word transfer: address phase then data phase
  task bus(input wr, input [7:0] a, input [31:0] wd, output [31:0] rd);
    begin
      i_hsel <= 1'b1;
      i_haddr <= {24'h000000, a};
      i_htrans <= 2'h2;
      i_hwrite <= wr;
      @(posedge i_clk_sys);
      while (!i_hready) @(posedge i_clk_sys);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= wd;
      @(posedge i_clk_sys);
      while (!i_hready) @(posedge i_clk_sys);
      rd = o_hrdata;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rchk(input [7:0] a, input [31:0] m, input [31:0] e);
    reg [31:0] x;
    begin
      bus(1'b0, a, 32'h0, x);
      cmp($sformatf("reg %h", a), e, x & m);
    end
  endtask
  // read a busy bit until it drops
  task poll(input [7:0] a);
    reg [31:0] x;
    integer n;
    begin
      x = 32'h1;
      for (n = 0; n < 5000 && x[0] !== 1'b0; n = n + 1) bus(1'b0, a, 32'h0, x);
      cmp("busy", 32'h0, {31'h0, x[0]});
    end
  endtask
  task t_reset;
    begin
      rchk(`MPF_ADDR_ACCESS, 32'hFFFFFFFF, `MPF_RST_ACCESS);
      rchk(`MPF_ADDR_DATA, 32'hFFFFFFFF, `MPF_RST_DATA);
      rchk(`MPF_ADDR_FLOW, 32'hFFFFFFFF, `MPF_RST_FLOW);
      rchk(`MPF_ADDR_CTRL, 32'hFFFFFFFF, `MPF_RST_CTRL);
      wr(8'h40, 32'hFFFFFFFF);
      rchk(8'h40, 32'hFFFFFFFF, 32'h0);
      wr(`MPF_ADDR_ACCESS, 32'h00000840);
      rchk(`MPF_ADDR_ACCESS, 32'h1, 32'h0);
      $display("test reset done");
    end
  endtask
  // phy write, with a data write refused while busy
  task t_mgmt_wr;
    begin
      wr(`MPF_ADDR_DATA, 32'h0000BEEF);
      wr(`MPF_ADDR_ACCESS, 32'h00000943);
      rchk(`MPF_ADDR_ACCESS, 32'h1, 32'h1);
      wr(`MPF_ADDR_DATA, 32'h00001111);
      poll(`MPF_ADDR_ACCESS);
      cmp("phy reg 5", 32'h0000BEEF, {16'h0, i_phy.regs[5]});
      rchk(`MPF_ADDR_DATA, 32'hFFFF, 32'hBEEF);
      $display("test mgmt write done");
    end
  endtask
  task t_mgmt_rd(input [31:0] acc, input [31:0] e);
    begin
      wr(`MPF_ADDR_ACCESS, acc);
      poll(`MPF_ADDR_ACCESS);
      rchk(`MPF_ADDR_DATA, 32'hFFFF, e);
      $display("test mgmt read done");
    end
  endtask
  // full duplex pause frame with a stalling sink
  task t_pause;
    reg [143:0] h;
    reg [7:0]   b;
    integer     n, t;
    begin
      h = 144'h0180C2000001_000000000000_8808_0001_A5C3;
      wr(`MPF_ADDR_CTRL, 32'h00000003);
      wr(`MPF_ADDR_FLOW, 32'hA5C30000);
      wr(`MPF_ADDR_FLOW, 32'hA5C30002);
      i_pause_req <= 1'b1;
      @(posedge i_clk_sys);
      i_pause_req <= 1'b0;
      rchk(`MPF_ADDR_FLOW, 32'h1, 32'h1);
      n = 0;
      for (t = 0; t < 2000 && n < 60; t = t + 1) begin
        @(posedge i_clk_sys);
        if (o_tx_valid && i_tx_ready) begin
          b = n < 18 ? h[143 - 8 * n -: 8] : 8'h00;
          cmp("tx byte", {24'h0, b}, {24'h0, o_tx_data});
          cmp("tx last", {31'h0, n == 59}, {31'h0, o_tx_last});
          n = n + 1;
        end
        i_tx_ready <= t[0];
      end
      cmp("frame bytes", 60, n);
      rchk(`MPF_ADDR_FLOW, 32'h1, 32'h0);
      $display("test pause done");
    end
  endtask
  task t_txoff;
    integer t;
    begin
      wr(`MPF_ADDR_CTRL, 32'h00000002);
      i_pause_req <= 1'b1;
      i_bp_req <= 1'b1;
      for (t = 0; t < 200; t = t + 1) begin
        @(posedge i_clk_sys);
        if (o_tx_valid || o_backpressure) t = 1000;
      end
      i_pause_req <= 1'b0;
      i_bp_req <= 1'b0;
      cmp("tx while off", 200, t);
      $display("test tx off done");
    end
  endtask
  task t_bp;
    begin
      wr(`MPF_ADDR_CTRL, 32'h00000001);
      i_bp_req <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      cmp("bp on", 1, o_backpressure);
      rchk(`MPF_ADDR_FLOW, 32'h1, 32'h1);
      i_bp_req <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      cmp("bp off", 0, o_backpressure);
      rchk(`MPF_ADDR_FLOW, 32'h1, 32'h0);
      $display("test back pressure done");
    end
  endtask
  // one received frame end; checks status and filter bit
  task rx(input p, input f, input pr, input ef, input ec);
    reg sv, fo, ic;
    begin
      i_rx_done <= 1'b1;
      i_rx_is_pause <= p;
      i_rx_ok <= 1'b1;
      i_rx_filter_pass <= f;
      i_promisc <= pr;
      i_rx_quanta <= 16'h0002;
      @(posedge i_clk_sys);
      i_rx_done <= 1'b0;
      sv = 1'b0;
      fo = 1'b0;
      ic = 1'b0;
      repeat (2) begin
        #1;
        if (o_rx_stat_valid === 1'b1) {sv, fo, ic} = {1'b1, o_rx_filter_ok, o_rx_is_ctrl};
        @(posedge i_clk_sys);
      end
      cmp("stat valid", 1, sv);
      cmp("filter bit", ef, fo);
      cmp("ctrl frame", ec, ic);
    end
  endtask
  task t_rx;
    begin
      wr(`MPF_ADDR_CTRL, 32'h00000003);
      wr(`MPF_ADDR_FLOW, 32'h00000004);
      rx(1, 1, 0, 1, 0);
      cmp("pause off", 0, o_tx_pause);
      wr(`MPF_ADDR_CTRL, 32'h00000001);
      wr(`MPF_ADDR_FLOW, 32'h00000006);
      rx(1, 1, 0, 1, 1);
      cmp("pause hdx", 0, o_tx_pause);
      wr(`MPF_ADDR_CTRL, 32'h00000003);
      wr(`MPF_ADDR_FLOW, 32'h00000002);
      rx(0, 1, 0, 1, 0);
      rx(0, 0, 0, 0, 0);
      rx(1, 1, 0, 0, 1);
      repeat (1000) @(posedge i_clk_sys);
      cmp("paused", 1, o_tx_pause);
      repeat (100) @(posedge i_clk_sys);
      cmp("pause end", 0, o_tx_pause);
      rx(1, 0, 1, 1, 1);
      $display("test receive done");
    end
  endtask
  initial begin
    {i_rst_b, i_hsel, i_hwrite, i_pause_req, i_bp_req, i_tx_ready} = 6'h00;
    {i_rx_done, i_rx_is_pause, i_rx_ok, i_rx_filter_pass, i_promisc} = 5'h00;
    {i_haddr, i_hwdata, i_htrans, i_rx_quanta} = 82'h0;
    i_hsize = 3'h2;
    repeat (5) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_reset;
    t_mgmt_wr;
    t_mgmt_rd(32'h000008C1, 32'h3333);
    t_mgmt_rd(32'h000010C1, 32'hFFFF);
    t_mgmt_rd(32'h00000941, 32'hBEEF);
    t_pause;
    t_txoff;
    t_bp;
    t_rx;
    wrap_up;
  end
endmodule
